// ### logic/can_buf_regs.svh
// register offsets, field positions and reset values of the dual-role buffer block
`ifndef CAN_BUF_REGS_SVH
`define CAN_BUF_REGS_SVH
`define CBR_NUM_BUFS        6
`define CBR_NUM_DATA        8
`define CBR_ADDR_W          12
`define CBR_DIR_SEL_OFF     12'h000
`define CBR_TX_REQ_OFF      12'h004
`define CBR_TX_BUSY_OFF     12'h008
`define CBR_BUF_BASE        12'h100
`define CBR_BUF_STRIDE_LSB  6
`define CBR_BUF_IDX_MSB     9
`define CBR_FLD_EID_LOW     6'h00
`define CBR_FLD_EID_HIGH    6'h04
`define CBR_FLD_LEN_CODE    6'h08
`define CBR_FLD_FORMAT      6'h0C
`define CBR_FLD_DATA_LSB    6'h20
`define CBR_DIR_LSB         2
`define CBR_DIR_MSB         7
`define CBR_RTR_BIT         6
`define CBR_LEN_MSB         3
`define CBR_EXT_FRAME_BIT   3
`define CBR_DIR_RESET       6'h00
`define CBR_LEGACY_MODE     2'h0
`endif

// ### logic/can_buf_pkg.sv
// types shared by the dual-role buffer block
package can_buf_pkg;
  typedef enum logic [2:0] {
    FLD_NONE,
    FLD_EID_LOW,
    FLD_EID_HIGH,
    FLD_LEN_CODE,
    FLD_FORMAT,
    FLD_DATA
  } buf_field_t;
endpackage

// ### logic/can_msg_buffer.sv
// one message buffer: identifier, length code, format flag and eight data bytes
`timescale 1ns/1ns
`default_nettype none
`include "can_buf_regs.svh"
module can_msg_buffer (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   sw_we_i,
  input  wire can_buf_pkg::buf_field_t sw_field_i,
  input  wire logic [2:0]             sw_index_i,
  input  wire logic [7:0]             sw_wdata_i,
  input  wire logic                   hw_load_i,
  input  wire logic [15:0]            hw_ext_id_i,
  input  wire logic [3:0]             hw_length_i,
  input  wire logic                   hw_rtr_i,
  input  wire logic                   hw_extended_i,
  input  wire logic [63:0]            hw_data_i,
  output logic      [15:0]            ext_id_o,
  output logic      [3:0]             length_o,
  output logic                        rtr_o,
  output logic                        extended_o,
  output logic      [63:0]            data_o
);
  logic [7:0] id_low;
  logic [7:0] id_high;
  logic [3:0] length_code;
  logic       rtr;
  logic       extended;
  logic [7:0] data_bytes [`CBR_NUM_DATA];
  logic [7:0] next_id_low;
  logic [7:0] next_id_high;
  logic [3:0] next_length_code;
  logic       next_rtr;
  logic       next_extended;
  logic [7:0] next_data_bytes [`CBR_NUM_DATA];

  always_comb begin
    next_id_low      = id_low;
    next_id_high     = id_high;
    next_length_code = length_code;
    next_rtr         = rtr;
    next_extended    = extended;
    next_data_bytes  = data_bytes;
    if (hw_load_i) begin
      next_id_low      = hw_ext_id_i[7:0];
      next_id_high     = hw_ext_id_i[15:8];
      next_length_code = hw_length_i;
      next_rtr         = hw_rtr_i;
      next_extended    = hw_extended_i;
      for (int m = 0; m < `CBR_NUM_DATA; m++) begin
        next_data_bytes[m] = hw_data_i[m*8 +: 8];
      end
    end else if (sw_we_i) begin
      case (sw_field_i)
        can_buf_pkg::FLD_EID_LOW:  next_id_low = sw_wdata_i;
        can_buf_pkg::FLD_EID_HIGH: next_id_high = sw_wdata_i;
        can_buf_pkg::FLD_LEN_CODE: begin
          // bits 7, 5 and 4 are not stored
          next_length_code = sw_wdata_i[`CBR_LEN_MSB:0];
          next_rtr         = sw_wdata_i[`CBR_RTR_BIT];
        end
        can_buf_pkg::FLD_FORMAT:   next_extended = sw_wdata_i[`CBR_EXT_FRAME_BIT];
        can_buf_pkg::FLD_DATA:     next_data_bytes[sw_index_i] = sw_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      id_low      <= 8'h00;
      id_high     <= 8'h00;
      length_code <= 4'h0;
      rtr         <= 1'b0;
      extended    <= 1'b0;
      for (int m = 0; m < `CBR_NUM_DATA; m++) begin
        data_bytes[m] <= 8'h00;
      end
    end else begin
      id_low      <= next_id_low;
      id_high     <= next_id_high;
      length_code <= next_length_code;
      rtr         <= next_rtr;
      extended    <= next_extended;
      data_bytes  <= next_data_bytes;
    end
  end

  assign ext_id_o   = {id_high, id_low};
  assign length_o   = length_code;
  assign rtr_o      = rtr;
  assign extended_o = extended;
  for (genvar m = 0; m < `CBR_NUM_DATA; m++) begin : g_out
    assign data_o[m*8 +: 8] = data_bytes[m];
  end
endmodule
`default_nettype wire

// ### logic/can_dual_role_buffers.sv
// apb register block of six dual-role can message buffers
`timescale 1ns/1ns
`default_nettype none
`include "can_buf_regs.svh"
module can_dual_role_buffers (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire logic [1:0]               op_mode_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [`CBR_ADDR_W-1:0]   paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic                     rx_load_i,
  input  wire logic [2:0]               rx_buf_i,
  input  wire logic [15:0]              rx_ext_id_i,
  input  wire logic [3:0]               rx_length_i,
  input  wire logic                     rx_rtr_i,
  input  wire logic                     rx_extended_i,
  input  wire logic [63:0]              rx_data_i,
  input  wire logic [`CBR_NUM_BUFS-1:0] tx_busy_i,
  input  wire logic [`CBR_NUM_BUFS-1:0] tx_done_i,
  input  wire logic [2:0]               tx_buf_i,
  output logic      [`CBR_NUM_BUFS-1:0] transmit_request_o,
  output logic      [15:0]              tx_ext_id_o,
  output logic      [3:0]               tx_length_o,
  output logic                          tx_rtr_o,
  output logic                          tx_extended_o,
  output logic      [63:0]              tx_data_o
);
  logic [`CBR_NUM_BUFS-1:0] buffer_tx_direction_bits;
  logic [`CBR_NUM_BUFS-1:0] tx_pending;
  logic [31:0]              rd_data;
  logic                     rd_err;
  logic [15:0]              tx_ext_id;
  logic [3:0]               tx_length;
  logic                     tx_rtr;
  logic                     tx_extended;
  logic [63:0]              tx_data;
  logic [`CBR_NUM_BUFS-1:0] next_dir;
  logic [`CBR_NUM_BUFS-1:0] next_tx_pending;
  logic [31:0]              next_rd_data;
  logic                     next_rd_err;
  logic [15:0]              next_tx_ext_id;
  logic [3:0]               next_tx_length;
  logic                     next_tx_rtr;
  logic                     next_tx_extended;
  logic [63:0]              next_tx_data;

  logic [15:0] buf_ext_id   [`CBR_NUM_BUFS];
  logic [3:0]  buf_length   [`CBR_NUM_BUFS];
  logic        buf_rtr      [`CBR_NUM_BUFS];
  logic        buf_extended [`CBR_NUM_BUFS];
  logic [63:0] buf_data     [`CBR_NUM_BUFS];
  logic [`CBR_NUM_BUFS-1:0] buf_we;
  logic [`CBR_NUM_BUFS-1:0] buf_load;

  logic                      setup;
  logic                      write_take;
  logic                      enhanced_mode;
  logic                      buf_range;
  logic [2:0]                buf_idx;
  can_buf_pkg::buf_field_t   field;

  // decode of a field offset inside one buffer window
  function automatic can_buf_pkg::buf_field_t field_of(input logic [5:0] off);
    if (off == `CBR_FLD_EID_LOW) begin
      field_of = can_buf_pkg::FLD_EID_LOW;
    end else if (off == `CBR_FLD_EID_HIGH) begin
      field_of = can_buf_pkg::FLD_EID_HIGH;
    end else if (off == `CBR_FLD_LEN_CODE) begin
      field_of = can_buf_pkg::FLD_LEN_CODE;
    end else if (off == `CBR_FLD_FORMAT) begin
      field_of = can_buf_pkg::FLD_FORMAT;
    end else if (off[5] && off[1:0] == 2'h0) begin
      field_of = can_buf_pkg::FLD_DATA;
    end else begin
      field_of = can_buf_pkg::FLD_NONE;
    end
  endfunction

  // a buffer takes software writes only in transmit direction and while idle
  function automatic logic sw_writable(input logic [2:0] idx,
                                       input logic [`CBR_NUM_BUFS-1:0] dir,
                                       input logic [`CBR_NUM_BUFS-1:0] pend,
                                       input logic [`CBR_NUM_BUFS-1:0] busy);
    sw_writable = dir[idx] && !pend[idx] && !busy[idx];
  endfunction

  assign enhanced_mode = (op_mode_i != `CBR_LEGACY_MODE);
  assign setup         = psel_i && !penable_i;
  assign write_take    = psel_i && penable_i && pwrite_i && !rd_err;
  // six windows from the base need four index bits; a three-bit compare would wrap
  assign buf_range     = (paddr_i >= `CBR_BUF_BASE) &&
                         (paddr_i[`CBR_ADDR_W-1:`CBR_BUF_IDX_MSB+1] == '0) &&
                         (paddr_i[`CBR_BUF_IDX_MSB:`CBR_BUF_STRIDE_LSB] < 4'(`CBR_NUM_BUFS + 4));
  assign buf_idx       = 3'(paddr_i[`CBR_BUF_IDX_MSB:`CBR_BUF_STRIDE_LSB] - 4'h4);
  assign field         = buf_range ? field_of(paddr_i[`CBR_BUF_STRIDE_LSB-1:0]) : can_buf_pkg::FLD_NONE;

  for (genvar n = 0; n < `CBR_NUM_BUFS; n++) begin : g_buf
    assign buf_we[n]   = write_take && buf_idx == 3'(n) && field != can_buf_pkg::FLD_NONE &&
                         sw_writable(3'(n), buffer_tx_direction_bits, tx_pending, tx_busy_i);
    // hardware fills only receive-direction buffers
    assign buf_load[n] = rx_load_i && rx_buf_i == 3'(n) && !buffer_tx_direction_bits[n];
    can_msg_buffer u_buf (
      .sys_clk_i     (sys_clk_i),
      .rst_i         (rst_i),
      .sw_we_i       (buf_we[n]),
      .sw_field_i    (field),
      .sw_index_i    (paddr_i[4:2]),
      .sw_wdata_i    (pwdata_i[7:0]),
      .hw_load_i     (buf_load[n]),
      .hw_ext_id_i   (rx_ext_id_i),
      .hw_length_i   (rx_length_i),
      .hw_rtr_i      (rx_rtr_i),
      .hw_extended_i (rx_extended_i),
      .hw_data_i     (rx_data_i),
      .ext_id_o      (buf_ext_id[n]),
      .length_o      (buf_length[n]),
      .rtr_o         (buf_rtr[n]),
      .extended_o    (buf_extended[n]),
      .data_o        (buf_data[n])
    );
  end

  // read data and error are prepared in the setup cycle so the access phase needs no wait
  always_comb begin
    next_rd_data = rd_data;
    next_rd_err  = rd_err;
    if (setup) begin
      next_rd_data = 32'h0000_0000;
      next_rd_err  = 1'b0;
      if (!enhanced_mode) begin
        next_rd_err = 1'b1;
      end else if (paddr_i == `CBR_DIR_SEL_OFF) begin
        next_rd_data[`CBR_DIR_MSB:`CBR_DIR_LSB] = buffer_tx_direction_bits;
      end else if (paddr_i == `CBR_TX_REQ_OFF) begin
        next_rd_data[`CBR_NUM_BUFS-1:0] = tx_pending;
      end else if (paddr_i == `CBR_TX_BUSY_OFF) begin
        next_rd_data[`CBR_NUM_BUFS-1:0] = tx_busy_i;
      end else begin
        case (field)
          can_buf_pkg::FLD_EID_LOW:  next_rd_data[7:0] = buf_ext_id[buf_idx][7:0];
          can_buf_pkg::FLD_EID_HIGH: next_rd_data[7:0] = buf_ext_id[buf_idx][15:8];
          can_buf_pkg::FLD_LEN_CODE: begin
            // bits 7, 5, 4 stay zero in either direction
            next_rd_data[`CBR_RTR_BIT]   = buf_rtr[buf_idx];
            next_rd_data[`CBR_LEN_MSB:0] = buf_length[buf_idx];
          end
          can_buf_pkg::FLD_FORMAT:   next_rd_data[`CBR_EXT_FRAME_BIT] = buf_extended[buf_idx];
          can_buf_pkg::FLD_DATA:     next_rd_data[7:0] = buf_data[buf_idx][paddr_i[4:2]*8 +: 8];
          default:                   next_rd_err = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data <= 32'h0000_0000;
      rd_err  <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_err  <= next_rd_err;
    end
  end

  // direction and transmit request state
  always_comb begin
    next_dir        = buffer_tx_direction_bits;
    next_tx_pending = tx_pending & ~tx_done_i;
    if (write_take && paddr_i == `CBR_DIR_SEL_OFF) begin
      // software keeps to idle buffers when switching
      next_dir = pwdata_i[`CBR_DIR_MSB:`CBR_DIR_LSB];
    end
    if (write_take && paddr_i == `CBR_TX_REQ_OFF) begin
      // a request set in the cycle of completion wins; only transmit buffers accept one
      next_tx_pending = (pwdata_i[`CBR_NUM_BUFS-1:0] & buffer_tx_direction_bits) |
                        (tx_pending & pwdata_i[`CBR_NUM_BUFS-1:0] & ~tx_done_i);
    end
    next_tx_pending = next_tx_pending & next_dir;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      buffer_tx_direction_bits <= `CBR_DIR_RESET;
      tx_pending               <= '0;
    end else begin
      buffer_tx_direction_bits <= next_dir;
      tx_pending               <= next_tx_pending;
    end
  end

  // outgoing frame of the buffer the protocol engine selects
  always_comb begin
    next_tx_ext_id   = buf_ext_id[tx_buf_i];
    next_tx_length   = buf_length[tx_buf_i];
    next_tx_rtr      = buf_rtr[tx_buf_i];
    next_tx_extended = buf_extended[tx_buf_i];
    next_tx_data     = buf_data[tx_buf_i];
    if (tx_buf_i >= 3'(`CBR_NUM_BUFS)) begin
      next_tx_ext_id   = 16'h0000;
      next_tx_length   = 4'h0;
      next_tx_rtr      = 1'b0;
      next_tx_extended = 1'b0;
      next_tx_data     = 64'h0000_0000_0000_0000;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_ext_id   <= 16'h0000;
      tx_length   <= 4'h0;
      tx_rtr      <= 1'b0;
      tx_extended <= 1'b0;
      tx_data     <= 64'h0000_0000_0000_0000;
    end else begin
      tx_ext_id   <= next_tx_ext_id;
      tx_length   <= next_tx_length;
      tx_rtr      <= next_tx_rtr;
      tx_extended <= next_tx_extended;
      tx_data     <= next_tx_data;
    end
  end

  assign prdata_o           = rd_data;
  assign pready_o           = 1'b1;
  assign pslverr_o          = psel_i && penable_i && rd_err;
  assign transmit_request_o = tx_pending;
  assign tx_ext_id_o        = tx_ext_id;
  assign tx_length_o        = tx_length;
  assign tx_rtr_o           = tx_rtr;
  assign tx_extended_o      = tx_extended;
  assign tx_data_o          = tx_data;
endmodule
`default_nettype wire

// ### tb/can_dual_role_buffers_sva.sv
// assertions on the ports of the dual-role can buffer register block
`timescale 1ns/1ns
`default_nettype none
`include "can_buf_regs.svh"
module can_dual_role_buffers_sva (
  input wire logic                     sys_clk_i,
  input wire logic                     rst_i,
  input wire logic [1:0]               op_mode_i,
  input wire logic                     psel_i,
  input wire logic                     penable_i,
  input wire logic                     pwrite_i,
  input wire logic [`CBR_ADDR_W-1:0]   paddr_i,
  input wire logic [31:0]              prdata_o,
  input wire logic                     pready_o,
  input wire logic                     pslverr_o,
  input wire logic                     rx_load_i,
  input wire logic [2:0]               tx_buf_i,
  input wire logic [`CBR_NUM_BUFS-1:0] tx_done_i,
  input wire logic [`CBR_NUM_BUFS-1:0] transmit_request_o,
  input wire logic                     tx_rtr_o,
  input wire logic [3:0]               tx_length_o,
  input wire logic [63:0]              tx_data_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire acc    = psel_i && penable_i;
  wire rd     = acc && !pwrite_i;
  wire wr     = acc && pwrite_i;
  wire req_wr = wr && paddr_i == `CBR_TX_REQ_OFF;
  // contents change only through a write or a load, so two quiet cycles with a steady tx_buf_i freeze the frame outputs
  wire quiet  = !wr && !rx_load_i;
  property p_legacy_err; acc && op_mode_i == `CBR_LEGACY_MODE |-> pslverr_o; endproperty
  a_legacy_err: assert property (p_legacy_err) else $error("legacy access not flagged");
  property p_legacy_rd0; rd && op_mode_i == `CBR_LEGACY_MODE |-> prdata_o == 32'h0; endproperty
  a_legacy_rd0: assert property (p_legacy_rd0) else $error("legacy read not zero");
  property p_err_in_access; pslverr_o |-> acc && pready_o; endproperty
  a_err_in_access: assert property (p_err_in_access) else $error("error outside access phase");
  property p_dir_low_zero; rd && paddr_i == `CBR_DIR_SEL_OFF |-> prdata_o[1:0] == 2'h0 && prdata_o[31:8] == 24'h0; endproperty
  a_dir_low_zero: assert property (p_dir_low_zero) else $error("direction spare bits set");
  property p_len_zero_bits;
    rd && paddr_i >= 12'h100 && paddr_i < 12'h280 && paddr_i[5:0] == `CBR_FLD_LEN_CODE
      |-> prdata_o[31:7] == 25'h0 && prdata_o[5:4] == 2'h0;
  endproperty
  a_len_zero_bits: assert property (p_len_zero_bits) else $error("length code spare bits set");
  property p_done_clears; (tx_done_i & transmit_request_o) != 6'h0 && !req_wr |=> (transmit_request_o & $past(tx_done_i)) == 6'h0; endproperty
  a_done_clears: assert property (p_done_clears) else $error("request kept after frame sent");
  property p_req_from_write; (transmit_request_o & ~$past(transmit_request_o)) != 6'h0 |-> $past(req_wr); endproperty
  a_req_from_write: assert property (p_req_from_write) else $error("request rose without write");
  property p_tx_hold; quiet ##1 (quiet && $stable(tx_buf_i)) |=> $stable({tx_rtr_o, tx_length_o, tx_data_o}); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame output moved without cause");
  c_tx_done: cover property (tx_done_i != 6'h0);
  c_rx_load: cover property (rx_load_i);
  c_legacy: cover property (acc && op_mode_i == `CBR_LEGACY_MODE);
endmodule
bind can_dual_role_buffers can_dual_role_buffers_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_mode_i(op_mode_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_load_i(rx_load_i), .tx_buf_i(tx_buf_i), .tx_done_i(tx_done_i),
  .transmit_request_o(transmit_request_o), .tx_rtr_o(tx_rtr_o), .tx_length_o(tx_length_o), .tx_data_o(tx_data_o));
`default_nettype wire

// ### tb/can_bus_node_model.sv
// behavioural model of the protocol engine and the other nodes on the bus
`timescale 1ns/1ns
`default_nettype none
module can_bus_node_model (
  input  wire logic        sys_clk_i,
  input  wire logic        slow_i,
  input  wire logic [5:0]  transmit_request_i,
  output logic             rx_load_o,
  output logic [2:0]       rx_buf_o,
  output logic [15:0]      rx_ext_id_o,
  output logic [3:0]       rx_length_o,
  output logic             rx_rtr_o,
  output logic             rx_extended_o,
  output logic [63:0]      rx_data_o,
  output logic [5:0]       tx_busy_o,
  output logic [5:0]       tx_done_o,
  output logic [2:0]       tx_buf_o
);
  logic [88:0] frame = '0;
  int          n;
  // outside the pulse the fields show their inverse, so a stale frame never passes for a fresh one
  assign {rx_buf_o, rx_ext_id_o, rx_length_o, rx_rtr_o, rx_extended_o, rx_data_o} = rx_load_o ? frame : ~frame;
  task automatic deliver(input logic [2:0] b, input logic [15:0] id, input logic [3:0] len, input logic rtr,
                         input logic [63:0] d);
    @(posedge sys_clk_i);
    frame     <= {b, id, len, rtr, 1'b1, d};
    rx_load_o <= 1'b1;
    @(posedge sys_clk_i);
    rx_load_o <= 1'b0;
  endtask
  initial begin
    rx_load_o = 1'b0;
    tx_busy_o = 6'h00;
    tx_done_o = 6'h00;
    tx_buf_o  = 3'h0;
    forever begin
      @(posedge sys_clk_i);
      if (transmit_request_i != 6'h00) begin
        n = 0;
        while (!transmit_request_i[n]) n++;
        tx_buf_o     <= 3'(n);
        tx_busy_o[n] <= 1'b1;
        repeat (slow_i ? 12 : 2) @(posedge sys_clk_i);
        tx_busy_o[n] <= 1'b0;
        tx_done_o[n] <= 1'b1;
        @(posedge sys_clk_i);
        tx_done_o[n] <= 1'b0;
        @(posedge sys_clk_i);
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of the dual-role can buffer register block
`timescale 1ns/1ns
`default_nettype none
`include "can_buf_regs.svh"
module tb_top;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [1:0]  op_mode_i = 2'h1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic        slow      = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, rx_load_i, rx_rtr_i, rx_extended_i, tx_rtr_o, tx_extended_o;
  logic [2:0]  rx_buf_i, tx_buf_i;
  logic [3:0]  rx_length_i, tx_length_o, len;
  logic [15:0] rx_ext_id_i, tx_ext_id_o, id;
  logic [63:0] rx_data_i, tx_data_o, dd;
  logic [5:0]  tx_busy_i, tx_done_i, transmit_request_o;
  logic [32:0] re;
  logic [32:0] rd_q[$];
  logic [85:0] fr_q[$];
  int          fails = 0;
  int          checks_done = 0;
  int          i, m, k, b;
  can_dual_role_buffers dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_mode_i(op_mode_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_load_i(rx_load_i), .rx_buf_i(rx_buf_i),
    .rx_ext_id_i(rx_ext_id_i), .rx_length_i(rx_length_i), .rx_rtr_i(rx_rtr_i), .rx_extended_i(rx_extended_i),
    .rx_data_i(rx_data_i), .tx_busy_i(tx_busy_i), .tx_done_i(tx_done_i), .tx_buf_i(tx_buf_i),
    .transmit_request_o(transmit_request_o), .tx_ext_id_o(tx_ext_id_o), .tx_length_o(tx_length_o),
    .tx_rtr_o(tx_rtr_o), .tx_extended_o(tx_extended_o), .tx_data_o(tx_data_o));
  can_bus_node_model node (.sys_clk_i(sys_clk_i), .slow_i(slow), .transmit_request_i(transmit_request_o),
    .rx_load_o(rx_load_i), .rx_buf_o(rx_buf_i), .rx_ext_id_o(rx_ext_id_i), .rx_length_o(rx_length_i),
    .rx_rtr_o(rx_rtr_i), .rx_extended_o(rx_extended_i), .rx_data_o(rx_data_i), .tx_busy_o(tx_busy_i),
    .tx_done_o(tx_done_i), .tx_buf_o(tx_buf_i));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [85:0] got, input logic [85:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bad;
    fails++;
    test_done();
  endtask
  // one setup cycle, then access until pready; signals move only just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    if (!w) rd_q.push_back(e);
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (n >= 40) bad();
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] v);
    apb(1'b0, a, 32'h0, {25'h0, v});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v}, 33'h0);
  endtask
  function automatic logic [11:0] ba(input int n, input logic [5:0] f);
    return `CBR_BUF_BASE + 12'(n * 64) + 12'(f);
  endfunction
  always @(posedge sys_clk_i) begin
    if (psel_i && penable_i && pready_o && !pwrite_i) begin
      re = rd_q.size() > 0 ? rd_q.pop_front() : 33'h1FFFFFFFF;
      check(86'(pslverr_o), 86'(re[32]));
      if (!re[32]) check(86'(prdata_o), 86'(re[31:0]));
    end
    if (tx_done_i != 6'h00)
      check({tx_ext_id_o, tx_length_o, tx_rtr_o, tx_extended_o, tx_data_o}, fr_q.size() > 0 ? fr_q.pop_front() : '1);
  end
  initial begin
    void'($urandom(32'h4445844B));
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(`CBR_DIR_SEL_OFF, 8'h00);
    op_mode_i <= 2'h0;
    wr(`CBR_DIR_SEL_OFF, 8'hFF);
    apb(1'b0, `CBR_DIR_SEL_OFF, 32'h0, {1'b1, 32'h0});
    op_mode_i <= 2'h2;
    rd(`CBR_DIR_SEL_OFF, 8'h00);
    wr(`CBR_DIR_SEL_OFF, 8'hFF);
    rd(`CBR_DIR_SEL_OFF, 8'hFC);
    apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
    wr(`CBR_DIR_SEL_OFF, 8'hF0);
    wr(`CBR_TX_REQ_OFF, 8'h03);
    rd(`CBR_TX_REQ_OFF, 8'h00);
    node.deliver(3'h2, 16'hFFFF, 4'h8, 1'b1, '1);
    rd(ba(2, `CBR_FLD_EID_LOW), 8'h00);
    for (i = 0; i < 2; i++) begin
      id  = 16'($urandom);
      dd  = {$urandom, $urandom};
      len = i[0] ? 4'h8 : 4'h0;
      node.deliver(3'(i), id, len, i[0], dd);
      rd(ba(i, `CBR_FLD_EID_LOW), id[7:0]);
      rd(ba(i, `CBR_FLD_EID_HIGH), id[15:8]);
      rd(ba(i, `CBR_FLD_LEN_CODE), {1'b0, i[0], 2'h0, len});
      wr(ba(i, `CBR_FLD_EID_LOW), ~id[7:0]);
      rd(ba(i, `CBR_FLD_EID_LOW), id[7:0]);
      for (m = 0; m < 8; m++) rd(ba(i, `CBR_FLD_DATA_LSB + 6'(4 * m)), dd[8*m +: 8]);
    end
    for (i = 0; i < 2; i++) begin
      b    = 2 + i;
      slow <= i[0];
      id   = 16'($urandom);
      dd   = {$urandom, $urandom};
      len  = i[0] ? 4'h8 : 4'h0;
      wr(ba(b, `CBR_FLD_EID_LOW), id[7:0]);
      wr(ba(b, `CBR_FLD_EID_HIGH), id[15:8]);
      wr(ba(b, `CBR_FLD_LEN_CODE), {1'b1, i[0], 2'h3, len});
      wr(ba(b, `CBR_FLD_FORMAT), {4'h0, i[0], 3'h0});
      for (m = 0; m < 8; m++) wr(ba(b, `CBR_FLD_DATA_LSB + 6'(4 * m)), dd[8*m +: 8]);
      rd(ba(b, `CBR_FLD_LEN_CODE), {1'b0, i[0], 2'h0, len});
      fr_q.push_back({id, len, i[0], i[0], dd});
      wr(`CBR_TX_REQ_OFF, 8'(1 << b));
      wr(ba(b, `CBR_FLD_DATA_LSB), ~dd[7:0]);
      rd(ba(b, `CBR_FLD_DATA_LSB), dd[7:0]);
      @(posedge sys_clk_i);
      k = 0;
      while (transmit_request_o !== 6'h00 && k < 100) begin
        @(posedge sys_clk_i);
        k++;
      end
      if (k >= 100) bad();
      rd(`CBR_TX_REQ_OFF, 8'h00);
    end
    test_done();
  end
endmodule
`default_nettype wire
